// file: rtl/dimmer_pkg.sv
// Constants shared by the pulse-count LED dimmer design files
`default_nettype none
package dimmer_pkg;
  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int unsigned CLK_KHZ       = 25000;   // mclk rate, 40 ns period
  localparam int unsigned OFF_TIMEOUT_US = 1000;   // Least low time that switches off
  localparam int unsigned LATCH_US       = 1000;   // Least high time that applies a burst
  localparam int unsigned ACCESS_MIN_US  = 1000;   // Earliest start of counting pulses
  localparam int unsigned ACCESS_MAX_US  = 5000;   // Latest start, then full scale
  // Least times round up; these divide exactly at 25 MHz
  localparam int unsigned OFF_CYC        = (OFF_TIMEOUT_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned LATCH_CYC      = (LATCH_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned ACCESS_MIN_CYC = (ACCESS_MIN_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned ACCESS_MAX_CYC = (ACCESS_MAX_US * CLK_KHZ + 999) / 1000;

  // ==========================================================
  // Widths, limits and reset values
  // ==========================================================
  localparam int TIMER_W = 17;                     // Holds 5 ms of cycles
  localparam logic [4:0] COUNT_MAX   = 5'h10;      // Counts above sixteen read as sixteen
  localparam logic [4:0] COUNT_RST   = 5'h00;
  localparam logic [3:0] LEVEL_RST   = 4'h0;       // Code 0 is index 1, full scale
  localparam logic [3:0] LEVEL_FULL  = 4'h0;
  localparam logic [7:0] CURRENT_RST = 8'hA0;

  // Sink current in steps of 0.125 mA, indexed by level code (index minus one)
  localparam logic [7:0] CURRENT_TABLE [16] = '{
    8'hA0, 8'h88, 8'h70, 8'h60, 8'h50, 8'h44, 8'h38, 8'h30,
    8'h28, 8'h20, 8'h18, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01
  };

  // ==========================================================
  // Interface states
  // ==========================================================
  typedef enum logic [1:0] {
    ST_OFF,
    ST_ACCESS,
    ST_COUNT,
    ST_ON
  } link_state_t;
endpackage
`default_nettype wire

// file: rtl/current_lookup.sv
// Registered lookup from level code to sink current code
`timescale 1ns/1ps
`default_nettype none
module current_lookup
(
  input  wire logic       mclk,        // System clock
  input  wire logic       rst_b,       // Async reset, active low
  input  wire logic [3:0] level,       // Level code, index minus one
  output logic      [7:0] current      // Sink current, 0.125 mA steps
);
  import dimmer_pkg::*;
  // ==========================================================
  // Table read
  // ==========================================================
  logic [7:0] next_current;            // Table entry for this level

  // Fixed sixteen-entry table, no software path
  always_comb
  begin
    next_current = CURRENT_TABLE[level];  // see [R10]
  end

  // Register so the output leaves a flip-flop
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      current <= CURRENT_RST;
    else
      current <= next_current;
  end
endmodule // current_lookup
`default_nettype wire

// file: rtl/pulse_count_led_dimmer.sv
// Single-pin pulse-count control of a four-sink LED driver
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [R1] Current level set only through enable pin
// [R2] Enable pulses switch sinks and set level
// [R3] Count rising edges, saturate at sixteen
// [R4] Host keeps pulse and gap widths legal
// [R5] Host starts pulses within access window
// [R6] High past access window gives full current
// [R7] Low for off timeout resets and disables
// [R8] New burst while lit changes the level
// [R9] Level applied after high for latch interval
// [R10] Index one to sixteen decreasing current table
// [R11] PWM gate input switches sinks on/off
// [R12] Host keeps PWM high phases long enough
module pulse_count_led_dimmer
#(
  parameter int unsigned OFF_CYCLES    = dimmer_pkg::OFF_CYC,        // Off timeout in cycles
  parameter int unsigned LATCH_CYCLES  = dimmer_pkg::LATCH_CYC,      // Latch interval in cycles
  parameter int unsigned ACCESS_CYCLES = dimmer_pkg::ACCESS_MAX_CYC  // Access window end in cycles
)
(
  input  wire logic       mclk,              // System clock, 25 MHz
  input  wire logic       rst_b,             // Async reset, active low
  input  wire logic       enable_pin,        // Single-wire on/off and dimming input
  input  wire logic       pwm_gate_input,    // External PWM gate, high lets current flow
  output logic            driver_on,         // Driver enabled, sinks lit by setting
  output logic [3:0]      level_code,        // Chosen level, index minus one
  output logic [7:0]      sink_current,      // Sink current, 0.125 mA steps
  output logic            led_sink_output_a, // Sink a gate
  output logic            led_sink_output_b, // Sink b gate
  output logic            led_sink_output_c, // Sink c gate
  output logic            led_sink_output_d  // Sink d gate
);
  import dimmer_pkg::*;
  // ==========================================================
  // Constants sized for the timers
  // ==========================================================
  localparam logic [TIMER_W-1:0] OFF_T    = TIMER_W'(OFF_CYCLES);
  localparam logic [TIMER_W-1:0] LATCH_T  = TIMER_W'(LATCH_CYCLES);
  localparam logic [TIMER_W-1:0] ACCESS_T = TIMER_W'(ACCESS_CYCLES);

  // ==========================================================
  // State
  // ==========================================================
  link_state_t        state;           // Protocol state
  link_state_t        next_state;
  logic               en_q;            // Last sample of the pin, for edges
  logic [TIMER_W-1:0] low_cnt;         // Consecutive low cycles, saturating
  logic [TIMER_W-1:0] next_low_cnt;
  logic [TIMER_W-1:0] high_cnt;        // Consecutive high cycles, saturating
  logic [TIMER_W-1:0] next_high_cnt;
  logic [4:0]         pulse_cnt;       // Rising edges in the current burst
  logic [4:0]         next_pulse_cnt;
  logic               next_driver_on;
  logic [3:0]         next_level_code;
  logic               next_sink;       // Common gate for all four sinks
  logic               en_rise;         // Pin went high this cycle
  logic               en_fall;         // Pin went low this cycle
  logic               off_hit;         // Low long enough to switch off

  // ==========================================================
  // Edge and duration detection
  // ==========================================================
  // Pin is synchronous to mclk, so one sample is enough for edges
  always_comb
  begin
    en_rise       = enable_pin & ~en_q;
    en_fall       = ~enable_pin & en_q;
    // Saturation keeps a long steady level from wrapping to a short one
    next_low_cnt  = enable_pin ? '0 : ((low_cnt == '1) ? low_cnt : low_cnt + 1'b1);
    next_high_cnt = !enable_pin ? '0 : ((high_cnt == '1) ? high_cnt : high_cnt + 1'b1);
    off_hit       = !enable_pin && (next_low_cnt >= OFF_T);  // see [R7]
  end

  // ==========================================================
  // Protocol state machine
  // ==========================================================
  // Only the enable pin moves this machine; nothing else sets the level
  always_comb
  begin
    next_state      = state;
    next_pulse_cnt  = pulse_cnt;
    next_driver_on  = driver_on;
    next_level_code = level_code;  // see [R1]
    unique case (state)
      ST_OFF:
      begin
        // Parked with sinks dark until the pin rises
        if (en_rise)
          next_state = ST_ACCESS;
      end
      ST_ACCESS:
      begin
        if (off_hit)
        begin
          next_state = ST_OFF;
        end
        else if (en_fall)
        begin
          // First low gap opens a counting burst
          next_state     = ST_COUNT;
          next_pulse_cnt = COUNT_RST;
        end
        else if (enable_pin && next_high_cnt >= ACCESS_T)
        begin
          // No pulses in the window: start at full scale
          next_state      = ST_ON;          // see [R6]
          next_level_code = LEVEL_FULL;     // see [R6]
          next_driver_on  = 1'b1;           // see [R2]
        end
      end
      ST_COUNT:
      begin
        if (off_hit)
        begin
          next_state = ST_OFF;
        end
        else
        begin
          if (en_rise && pulse_cnt != COUNT_MAX)
            next_pulse_cnt = pulse_cnt + 5'h01;  // see [R3]
          // Pin held high after the burst: take the count
          if (enable_pin && next_high_cnt >= LATCH_T && pulse_cnt != COUNT_RST)
          begin
            next_state      = ST_ON;                     // see [R9]
            next_level_code = 4'(pulse_cnt - 5'h01);     // see [R9]
            next_driver_on  = 1'b1;                      // see [R2]
          end
        end
      end
      ST_ON:
      begin
        // A new burst keeps the old level lit until it latches
        if (en_fall)
        begin
          next_state     = ST_COUNT;   // see [R8]
          next_pulse_cnt = COUNT_RST;  // see [R8]
        end
      end
    endcase
    // Off timeout wins over all: dark and back to reset values
    if (off_hit)
    begin
      next_driver_on  = 1'b0;       // see [R7]
      next_level_code = LEVEL_RST;  // see [R7]
      next_pulse_cnt  = COUNT_RST;
    end
    // PWM gates the sinks, using the set level as on current
    next_sink = next_driver_on & pwm_gate_input;  // see [R11]
  end

  // Register every piece of state; all outputs but sink_current leave these flops
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state             <= ST_OFF;
      en_q              <= 1'b0;
      low_cnt           <= '0;
      high_cnt          <= '0;
      pulse_cnt         <= COUNT_RST;
      driver_on         <= 1'b0;
      level_code        <= LEVEL_RST;
      led_sink_output_a <= 1'b0;
      led_sink_output_b <= 1'b0;
      led_sink_output_c <= 1'b0;
      led_sink_output_d <= 1'b0;
    end
    else
    begin
      state             <= next_state;
      en_q              <= enable_pin;
      low_cnt           <= next_low_cnt;
      high_cnt          <= next_high_cnt;
      pulse_cnt         <= next_pulse_cnt;
      driver_on         <= next_driver_on;
      level_code        <= next_level_code;
      led_sink_output_a <= next_sink;
      led_sink_output_b <= next_sink;
      led_sink_output_c <= next_sink;
      led_sink_output_d <= next_sink;
    end
  end

  // ==========================================================
  // Current table
  // ==========================================================
  // Table sits one cycle behind the level code
  current_lookup u_lookup
  (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .level   (level_code),
    .current (sink_current)
  );

  // ==========================================================
  // Assertions
  // ==========================================================
  property p_off_timeout;
    @(posedge mclk) disable iff (!rst_b)
      (!enable_pin && low_cnt == OFF_T - 1'b1) |=> (!driver_on && state == ST_OFF && !led_sink_output_a);
  endproperty
  a_off_timeout: assert property (p_off_timeout) else $error("driver not off after timeout"); // see [R7]

  property p_count_cap;
    @(posedge mclk) disable iff (!rst_b)
      pulse_cnt <= COUNT_MAX;
  endproperty
  a_count_cap: assert property (p_count_cap) else $error("pulse count above sixteen"); // see [R3]

  property p_rise_counts;
    @(posedge mclk) disable iff (!rst_b)
      (state == ST_COUNT && en_rise && !off_hit) |=> (pulse_cnt == (($past(pulse_cnt) == COUNT_MAX) ?
        COUNT_MAX : $past(pulse_cnt) + 5'h01));
  endproperty
  a_rise_counts: assert property (p_rise_counts) else $error("rising edge not counted"); // see [R3]

  property p_latch_applies;
    @(posedge mclk) disable iff (!rst_b)
      (state == ST_COUNT && enable_pin && high_cnt == LATCH_T - 1'b1 && pulse_cnt != COUNT_RST)
        |=> (driver_on && state == ST_ON && level_code == 4'($past(pulse_cnt) - 5'h01));
  endproperty
  a_latch_applies: assert property (p_latch_applies) else $error("burst count not latched"); // see [R9]

  property p_full_default;
    @(posedge mclk) disable iff (!rst_b)
      (state == ST_ACCESS && enable_pin && high_cnt == ACCESS_T - 1'b1)
        |=> (driver_on && level_code == LEVEL_FULL) ##1 (sink_current == CURRENT_TABLE[0]);
  endproperty
  a_full_default: assert property (p_full_default) else $error("no full scale after window"); // see [R6]

  property p_burst_keeps_lit;
    @(posedge mclk) disable iff (!rst_b)
      (state == ST_ON && en_fall) |=> (state == ST_COUNT && driver_on && $stable(level_code));
  endproperty
  a_burst_keeps_lit: assert property (p_burst_keeps_lit) else $error("burst darkened sinks"); // see [R8]

  property p_pwm_gate;
    @(posedge mclk) disable iff (!rst_b)
      (driver_on && !off_hit) |=> (led_sink_output_d == $past(pwm_gate_input));
  endproperty
  a_pwm_gate: assert property (p_pwm_gate) else $error("sink ignores pwm gate"); // see [R11]

  property p_level_only_latch;
    @(posedge mclk) disable iff (!rst_b)
      $changed(level_code) |-> ($past(state) != ST_ON && ($past(off_hit) || driver_on));
  endproperty
  a_level_only_latch: assert property (p_level_only_latch) else $error("level changed outside latch"); // see [R2]

  property p_table;
    @(posedge mclk) disable iff (!rst_b)
      ##1 (sink_current == CURRENT_TABLE[$past(level_code)]);
  endproperty
  a_table: assert property (p_table) else $error("sink current not from table"); // see [R10]

  c_full_start: cover property (@(posedge mclk) disable iff (!rst_b) state == ST_ACCESS ##1 state == ST_ON);
  c_latched: cover property (@(posedge mclk) disable iff (!rst_b) state == ST_COUNT ##1 state == ST_ON);
  c_saturated: cover property (@(posedge mclk) disable iff (!rst_b) pulse_cnt == COUNT_MAX && en_rise);
  c_off: cover property (@(posedge mclk) disable iff (!rst_b) driver_on ##1 !driver_on);
endmodule // pulse_count_led_dimmer
`default_nettype wire

// file: dv/enable_host.sv
// Host model that drives the enable pin and the PWM gate of the dimmer
`timescale 1ns/1ps
`default_nettype none
module enable_host
#(
  parameter int unsigned HIGH_CYC  = 2,  // 80 ns high pulse, above the least high time
  parameter int unsigned GAP_CYC   = 8,  // 320 ns low gap, above the least low time
  parameter int unsigned START_CYC = 10  // High time after first raise, inside the window
)
(
  input  wire logic mclk,          // System clock
  output var  logic enable_pin,    // Single-wire control line
  output var  logic pwm_gate_input // PWM gate, idles high
);
  // ==========================================================
  // Idle levels
  // ==========================================================
  initial enable_pin = 1'b0;
  initial pwm_gate_input = 1'b1; // Tied high while PWM is unused

  // ==========================================================
  // Pin drivers, all changed just after a rising edge
  // ==========================================================
  // Hold the pin at one level for a number of cycles
  task automatic drive_pin(input logic v, input int unsigned cyc);
    enable_pin <= v;
    repeat (cyc) @(posedge mclk);
  endtask

  // First raise, then wait before pulsing
  task automatic start();
    drive_pin(1'b1, START_CYC);
  endtask

  // Gap then pulse, both well inside the legal widths
  task automatic burst(input int unsigned n);
    for (int unsigned i = 0; i < n; i++)
    begin
      drive_pin(1'b0, GAP_CYC);
      drive_pin(1'b1, HIGH_CYC);
    end
  endtask

  // Gate change, held two edges so the sinks can follow
  task automatic set_pwm(input logic v);
    pwm_gate_input <= v;
    repeat (2) @(posedge mclk);
  endtask
endmodule // enable_host
`default_nettype wire

// file: dv/pulse_count_led_dimmer_tb.sv
// Self-checking testbench for the pulse-count LED dimmer
`timescale 1ns/1ps
`default_nettype none
module pulse_count_led_dimmer_tb;
  // ==========================================================
  // Shortened counts keep the run brief
  // ==========================================================
  localparam int unsigned OFF_N = 40;    // Off timeout, longer than a gap
  localparam int unsigned LAT_N = 16;    // Latch interval
  localparam int unsigned ACC_N = 60;    // Access window end
  localparam int unsigned LIMIT = 20000; // Hang ceiling in cycles
  // Sink current per level, 0.125 mA steps
  localparam logic [7:0] EXP_CUR [16] = '{
    8'hA0, 8'h88, 8'h70, 8'h60, 8'h50, 8'h44, 8'h38, 8'h30,
    8'h28, 8'h20, 8'h18, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01
  };

  logic        mclk = 1'b0;   // 40 ns clock
  logic        rst_b = 1'b0;  // Reset, active low
  wire         enable_pin;    // From host model
  wire         pwm_gate_input;
  logic        driver_on;
  logic [3:0]  level_code;
  logic [7:0]  sink_current;
  logic        sa, sb, sc, sd; // Sink gates
  int          err_count = 0;
  int          n_tests = 0;
  int unsigned cycles = 0;

  always #20 mclk = ~mclk;

  pulse_count_led_dimmer #(.OFF_CYCLES(OFF_N), .LATCH_CYCLES(LAT_N), .ACCESS_CYCLES(ACC_N)) i_dut (
    .mclk(mclk), .rst_b(rst_b), .enable_pin(enable_pin), .pwm_gate_input(pwm_gate_input),
    .driver_on(driver_on), .level_code(level_code), .sink_current(sink_current),
    .led_sink_output_a(sa), .led_sink_output_b(sb), .led_sink_output_c(sc), .led_sink_output_d(sd));

  // Start delay scaled like the window: past its fifth, short of its end
  enable_host #(.START_CYC(ACC_N / 2)) i_host (
    .mclk(mclk), .enable_pin(enable_pin), .pwm_gate_input(pwm_gate_input));

  // ==========================================================
  // Reporting
  // ==========================================================
  task automatic close_out();
    $display("Counts: %0d checks, %0d mismatches", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Sample at the falling edge so all updates have landed, then rejoin the rising edge
  task automatic check(input logic on, input logic [3:0] lvl, input logic [7:0] cur,
                       input logic snk, input string what);
    @(negedge mclk);
    n_tests++;
    if ({driver_on, level_code, sink_current, sa, sb, sc, sd} !== {on, lvl, cur, {4{snk}}})
    begin
      err_count++;
      $display("[ERR] %0t %s: on=%b lvl=%h cur=%h sinks=%b%b%b%b", $time, what,
               driver_on, level_code, sink_current, sa, sb, sc, sd);
    end
    @(posedge mclk);
  endtask

  // Hang guard: a run that never ends counts as a mismatch
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      err_count++;
      $display("[ERR] %0t hang guard reached after %0d cycles", $time, cycles);
      close_out();
    end
  end

  // ==========================================================
  // Scenarios
  // ==========================================================
  // Raise and hold with no pulses gives full scale
  task automatic t_full_scale();
    i_host.drive_pin(1'b1, ACC_N - 6);
    check(1'b0, 4'h0, 8'hA0, 1'b0, "early full scale");
    i_host.drive_pin(1'b1, 14);
    check(1'b1, 4'h0, 8'hA0, 1'b1, "full scale");
    $display("Done: full scale");
  endtask

  // Every burst length from 1 to 17 while lit; old level stands until latch
  task automatic t_levels();
    logic [3:0] prev;
    logic [3:0] lvl;
    prev = 4'h0;
    for (int unsigned n = 1; n <= 17; n++)
    begin
      lvl = (n > 16) ? 4'hF : 4'(n - 1);
      i_host.burst(n);
      i_host.drive_pin(1'b1, LAT_N - 6);
      check(1'b1, prev, EXP_CUR[prev], 1'b1, "before latch");
      i_host.drive_pin(1'b1, 12);
      check(1'b1, lvl, EXP_CUR[lvl], 1'b1, "after latch");
      prev = lvl;
    end
    $display("Done: levels");
  endtask

  // Gate low stops the sinks but keeps the setting
  task automatic t_pwm();
    i_host.set_pwm(1'b0);
    check(1'b1, 4'hF, 8'h01, 1'b0, "gate low");
    i_host.set_pwm(1'b1);
    check(1'b1, 4'hF, 8'h01, 1'b1, "gate high");
    $display("Done: pwm gate");
  endtask

  // Long low switches off and clears the level
  task automatic t_off();
    i_host.drive_pin(1'b0, OFF_N - 6);
    check(1'b1, 4'hF, 8'h01, 1'b1, "short low");
    i_host.drive_pin(1'b0, 10);
    check(1'b0, 4'h0, 8'hA0, 1'b0, "off");
    $display("Done: off timeout");
  endtask

  // Start from off with a counted burst
  task automatic t_start_burst();
    i_host.start();
    i_host.burst(3);
    i_host.drive_pin(1'b1, LAT_N + 8);
    check(1'b1, 4'h2, 8'h70, 1'b1, "start burst");
    $display("Done: start burst");
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    t_full_scale();
    t_levels();
    t_pwm();
    t_off();
    t_start_burst();
    close_out();
  end
endmodule // pulse_count_led_dimmer_tb
`default_nettype wire
